//--- hdl/spa_defs.svh
// Register offsets, field positions, reset values and timing counts of the PWM audio block
`ifndef SPA_DEFS_SVH
`define SPA_DEFS_SVH

// Register byte offsets
`define SPA_ADDR_CLKSEL 8'h00
`define SPA_ADDR_MODE 8'h04
`define SPA_ADDR_PERIOD 8'h08
`define SPA_ADDR_LEFT 8'h0c
`define SPA_ADDR_RIGHT 8'h10
`define SPA_ADDR_CHAN0 8'h14
`define SPA_ADDR_STATUS 8'h18
`define SPA_ADDR_COUNT 8'h1c
`define SPA_ADDR_STREAM 8'h20
`define SPA_ADDR_FADDR 8'h24
`define SPA_ADDR_SAMPLE 8'h28

// Field positions
`define SPA_MODE_RUN 0
`define SPA_MODE_BUF 1
`define SPA_STAT_PERIOD 0
`define SPA_STAT_BUSY 1
`define SPA_STAT_FULL 2
`define SPA_SAMPLE_VALID 4

// Reset values, with the clock, sample rate and audible limit figures of the default carrier
`define SPA_CLKSEL_RST 1'b1
`define SPA_SYS_CLK_HZ 50000000
`define SPA_FS_HZ 11025
`define SPA_PCF 3
`define SPA_AUDIBLE_HZ 20000
`define SPA_PERIOD_RST (`SPA_SYS_CLK_HZ / (`SPA_PCF * `SPA_FS_HZ) - 1)

// Serial flash link
`define SPA_FLASH_READ_CMD 8'h03
`define SPA_SPI_HALF_NS 40
`define SPA_CLK_NS 20
`define SPA_SPI_HALF_CYC (`SPA_SPI_HALF_NS / `SPA_CLK_NS)
`define SPA_SPI_BITS 6'd40

`endif

//--- hdl/spa_pkg.sv
// Types shared by the PWM audio block
package spa_pkg;
    typedef enum logic [1:0] {
        SPA_SP_IDLE = 2'b00,
        SPA_SP_SEL = 2'b01,
        SPA_SP_XFER = 2'b11,
        SPA_SP_DONE = 2'b10
    } spa_spi_state_type;

    typedef logic [15:0] spa_duty_type;
endpackage

//--- hdl/spa_pwm_audio.sv
// Stereo PWM audio output with AHB-Lite registers and serial flash sample fetch
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`include "spa_defs.svh"

module spa_pwm_audio (
    // AHB-Lite slave
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Audio and clock select
    output logic left_audio_pin,
    output logic right_audio_pin,
    output logic period_pulse,
    output logic cpu_clock_source_select,
    // Serial flash
    output logic serial_clock_pin,
    output logic serial_out_pin,
    input wire logic serial_in_pin,
    output logic flash_select_pin_n,
    // Type reference for the duty width
    output spa_pkg::spa_duty_type active_left_duty
);
    import spa_pkg::*;

    // Pin stays high while count is below duty; duty above period gives 100%
    function automatic logic pwm_level(input logic [15:0] cnt, input logic [15:0] duty);
        pwm_level = cnt < duty;
    endfunction

    logic clksel_q;
    logic [1:0] mode_q;
    logic [15:0] period_q;
    spa_duty_type left_q, right_q, chan0_q, act_left_q, act_right_q;
    logic [15:0] cnt_q;
    logic period_flag_q;
    logic stream_q;
    logic [23:0] faddr_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    spa_spi_state_type sp_state_q;
    logic [39:0] tx_q;
    logic [7:0] rx_q;
    logic [5:0] bit_cnt_q;
    logic [1:0] half_cnt_q;
    logic [7:0] byte_q;
    logic full_q;
    logic nib_sel_q;

    logic wrap_w;
    logic rd_take_w;
    logic consume_w;
    logic tick_w;
    logic [31:0] rd_mux_w;

    assign wrap_w = mode_q[`SPA_MODE_RUN] && (cnt_q >= period_q);
    assign rd_take_w = hsel && hready && htrans[1] && !hwrite;
    assign consume_w = rd_take_w && (haddr[7:0] == `SPA_ADDR_SAMPLE) && full_q;
    assign tick_w = (half_cnt_q == 2'(`SPA_SPI_HALF_CYC - 1));

    // Bus slave: zero wait state, writes land at the end of the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans[1] && hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    always_comb begin
        rd_mux_w = 32'h0000_0000;
        case (haddr[7:0])
            `SPA_ADDR_CLKSEL: rd_mux_w = {31'h0, clksel_q};
            `SPA_ADDR_MODE: rd_mux_w = {30'h0, mode_q};
            `SPA_ADDR_PERIOD: rd_mux_w = {16'h0, period_q};
            `SPA_ADDR_LEFT: rd_mux_w = {16'h0, left_q};
            `SPA_ADDR_RIGHT: rd_mux_w = {16'h0, right_q};
            `SPA_ADDR_CHAN0: rd_mux_w = {16'h0, chan0_q};
            `SPA_ADDR_STATUS: rd_mux_w = {29'h0, full_q, sp_state_q != SPA_SP_IDLE,
                period_flag_q};
            `SPA_ADDR_COUNT: rd_mux_w = {16'h0, cnt_q};
            `SPA_ADDR_STREAM: rd_mux_w = {31'h0, stream_q};
            `SPA_ADDR_FADDR: rd_mux_w = {8'h0, faddr_q};
            `SPA_ADDR_SAMPLE: rd_mux_w = {27'h0, full_q,
                nib_sel_q ? byte_q[7:4] : byte_q[3:0]};
            default: rd_mux_w = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (rd_take_w) begin
            hrdata <= rd_mux_w;
        end
    end

    // Control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clksel_q <= `SPA_CLKSEL_RST;
            mode_q <= 2'h0;
            period_q <= 16'(`SPA_PERIOD_RST);
            left_q <= 16'h0000;
            right_q <= 16'h0000;
            chan0_q <= 16'h0000;
            stream_q <= 1'b0;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                `SPA_ADDR_CLKSEL: clksel_q <= hwdata[0];
                `SPA_ADDR_MODE: mode_q <= hwdata[1:0];
                `SPA_ADDR_PERIOD: period_q <= hwdata[15:0];
                `SPA_ADDR_LEFT: left_q <= hwdata[15:0];
                `SPA_ADDR_RIGHT: right_q <= hwdata[15:0];
                `SPA_ADDR_CHAN0: chan0_q <= hwdata[15:0];
                `SPA_ADDR_STREAM: stream_q <= hwdata[0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_clock_source_select <= `SPA_CLKSEL_RST;
        end else begin
            cpu_clock_source_select <= clksel_q;
        end
    end

    // Carrier counter on the raw clock, so the period is in clock cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 16'h0000;
        end else if (!mode_q[`SPA_MODE_RUN]) begin
            cnt_q <= 16'h0000;
        end else if (wrap_w) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Active compares: direct in plain mode, transferred at wrap in buffered mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_left_q <= 16'h0000;
            act_right_q <= 16'h0000;
        end else if (mode_q[`SPA_MODE_BUF]) begin
            if (wrap_w) begin
                act_left_q <= chan0_q;
                act_right_q <= right_q;
            end
        end else begin
            act_left_q <= left_q;
            act_right_q <= right_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left_audio_pin <= 1'b0;
            right_audio_pin <= 1'b0;
            active_left_duty <= 16'h0000;
        end else begin
            left_audio_pin <= mode_q[`SPA_MODE_RUN] && pwm_level(cnt_q, act_left_q);
            right_audio_pin <= mode_q[`SPA_MODE_RUN] && pwm_level(cnt_q, act_right_q);
            active_left_duty <= act_left_q;
        end
    end

    // Period event: pulse plus sticky flag, write one to clear; a new event wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period_pulse <= 1'b0;
            period_flag_q <= 1'b0;
        end else begin
            period_pulse <= wrap_w;
            if (wrap_w) begin
                period_flag_q <= 1'b1;
            end else if (wr_pend_q && wr_addr_q == `SPA_ADDR_STATUS
                         && hwdata[`SPA_STAT_PERIOD]) begin
                period_flag_q <= 1'b0;
            end
        end
    end

    // Sample byte: low nibble first, then high, then the next byte is fetched
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            full_q <= 1'b0;
            nib_sel_q <= 1'b0;
            byte_q <= 8'h00;
        end else if (sp_state_q == SPA_SP_DONE) begin
            full_q <= 1'b1;
            nib_sel_q <= 1'b0;
            byte_q <= rx_q;
        end else if (consume_w) begin
            nib_sel_q <= !nib_sel_q;
            full_q <= !nib_sel_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            faddr_q <= 24'h00_0000;
        end else if (wr_pend_q && wr_addr_q == `SPA_ADDR_FADDR) begin
            faddr_q <= hwdata[23:0];
        end else if (sp_state_q == SPA_SP_DONE) begin
            faddr_q <= faddr_q + 24'h00_0001;
        end
    end

    // SPI mode 0 master, one read frame per byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            half_cnt_q <= 2'h0;
        end else if (sp_state_q != SPA_SP_XFER || tick_w) begin
            half_cnt_q <= 2'h0;
        end else begin
            half_cnt_q <= half_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_state_q <= SPA_SP_IDLE;
            flash_select_pin_n <= 1'b1;
            serial_clock_pin <= 1'b0;
            serial_out_pin <= 1'b0;
            tx_q <= 40'h00_0000_0000;
            rx_q <= 8'h00;
            bit_cnt_q <= 6'h00;
        end else begin
            case (sp_state_q)
                SPA_SP_IDLE: begin
                    // A new frame waits until both nibbles of the last byte are used
                    if (stream_q && !full_q) begin
                        sp_state_q <= SPA_SP_SEL;
                        tx_q <= {`SPA_FLASH_READ_CMD, faddr_q, 8'h00};
                    end
                end
                SPA_SP_SEL: begin
                    flash_select_pin_n <= 1'b0;
                    serial_out_pin <= tx_q[39];
                    tx_q <= {tx_q[38:0], 1'b0};
                    bit_cnt_q <= 6'h00;
                    sp_state_q <= SPA_SP_XFER;
                end
                SPA_SP_XFER: begin
                    if (tick_w) begin
                        if (!serial_clock_pin) begin
                            serial_clock_pin <= 1'b1;
                            rx_q <= {rx_q[6:0], serial_in_pin};
                            bit_cnt_q <= bit_cnt_q + 6'h01;
                        end else begin
                            serial_clock_pin <= 1'b0;
                            if (bit_cnt_q == `SPA_SPI_BITS) begin
                                sp_state_q <= SPA_SP_DONE;
                            end else begin
                                serial_out_pin <= tx_q[39];
                                tx_q <= {tx_q[38:0], 1'b0};
                            end
                        end
                    end
                end
                SPA_SP_DONE: begin
                    flash_select_pin_n <= 1'b1;
                    serial_out_pin <= 1'b0;
                    sp_state_q <= SPA_SP_IDLE;
                end
                default: sp_state_q <= SPA_SP_IDLE;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence low_nibble_taken;
        consume_w && !nib_sel_q;
    endsequence
    sequence high_nibble_taken;
        consume_w && nib_sel_q;
    endsequence
    sequence frame_open;
        sp_state_q == SPA_SP_SEL;
    endsequence
    sequence frame_close;
        sp_state_q == SPA_SP_DONE;
    endsequence
    clksel_write_a: assert property (
        wr_pend_q && wr_addr_q == `SPA_ADDR_CLKSEL |=> ##1
            cpu_clock_source_select == $past(hwdata[0], 2))
        else $error("clock select output does not follow write");
    nibble_first_a: assert property (
        low_nibble_taken and (sp_state_q != SPA_SP_DONE) |=> full_q && nib_sel_q)
        else $error("byte released after first nibble");
    nibble_second_a: assert property (
        high_nibble_taken and (sp_state_q != SPA_SP_DONE) |=> !full_q ##1
            (sp_state_q == SPA_SP_SEL || !stream_q))
        else $error("second nibble did not start next fetch");
    frame_select_a: assert property (
        frame_open |=> !flash_select_pin_n throughout (sp_state_q == SPA_SP_XFER)[*3])
        else $error("flash select not held during frame");
    frame_end_a: assert property (
        frame_close |=> flash_select_pin_n && full_q && byte_q == $past(rx_q))
        else $error("frame end did not release select and store byte");
    period_write_a: assert property (
        wr_pend_q && wr_addr_q == `SPA_ADDR_PERIOD |=> period_q == $past(hwdata[15:0]))
        else $error("period register not loaded");
    left_level_a: assert property (
        mode_q[`SPA_MODE_RUN] |=> left_audio_pin == ($past(cnt_q) < $past(act_left_q)))
        else $error("left pin level wrong");
    right_level_a: assert property (
        mode_q[`SPA_MODE_RUN] |=> right_audio_pin == ($past(cnt_q) < $past(act_right_q)))
        else $error("right pin level wrong");
    buffered_load_a: assert property (
        mode_q[`SPA_MODE_BUF] && wrap_w |=> act_left_q == $past(chan0_q)
            && act_right_q == $past(right_q))
        else $error("buffered duty not transferred at wrap");
    buffered_hold_a: assert property (
        mode_q[`SPA_MODE_BUF] && !wrap_w |=> $stable(act_left_q) && $stable(act_right_q))
        else $error("buffered duty changed mid period");
    count_step_a: assert property (
        mode_q[`SPA_MODE_RUN] && !wrap_w |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("counter did not step by one");
    wrap_restart_a: assert property (
        wrap_w |=> cnt_q == 16'h0000 ##1 (cnt_q == 16'h0001 || !mode_q[`SPA_MODE_RUN]
            || period_q == 16'h0000))
        else $error("counter did not restart at zero");
    period_event_a: assert property (
        wrap_w |=> period_pulse && period_flag_q)
        else $error("period event missing");
    carrier_audible_a: assert property (
        (`SPA_PCF * `SPA_FS_HZ) > `SPA_AUDIBLE_HZ)
        else $error("default carrier is audible");
endmodule

//--- tb/spa_flash_model.sv
// Behavioural serial flash on the far side of the sample fetch link
module spa_flash_model (
    // Serial link
    input wire logic sclk,
    input wire logic mosi,
    input wire logic cs_n,
    output logic miso,
    // Observed frame header
    output logic [7:0] last_cmd,
    output logic [23:0] last_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] sh;
    logic [7:0] dat;
    int n;
    initial begin
        miso = 1'b0;
        sh = 32'h0;
        dat = 8'h0;
        n = 0;
        last_cmd = 8'h0;
        last_addr = 24'h0;
    end
    always @(negedge cs_n) begin
        n = 0;
    end
    // Header shifts in on rising clock; data is a simple function of the address
    always @(posedge sclk) begin
        if (cs_n === 1'b0) begin
            sh = {sh[30:0], mosi};
            n++;
            if (n == 32) begin
                last_cmd = sh[31:24];
                last_addr = sh[23:0];
                dat = sh[7:0] ^ 8'h5a;
            end
        end
    end
    // Mode 0: data changes on falling clock, MSB first, after the header
    always @(negedge sclk) begin
        if (cs_n === 1'b0 && n >= 32 && n < 40) begin
            miso <= dat[39 - n];
        end
    end
    // No pull on the line, so a released output must not keep its old value
    always @(posedge cs_n) begin
        miso <= ~miso;
    end
endmodule

//--- tb/tb.sv
// Testbench for the stereo PWM audio block
`include "spa_defs.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import spa_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready, hreadyout, hresp, left_audio_pin, right_audio_pin, period_pulse;
    logic cpu_clock_source_select, serial_clock_pin, serial_out_pin, serial_in_pin;
    logic flash_select_pin_n;
    logic [31:0] hrdata, rd;
    spa_duty_type active_left_duty;
    logic [7:0] last_cmd;
    logic [23:0] last_addr;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    int nl, nr, np;

    always #10 hclk = ~hclk;
    assign hready = hreadyout;

    spa_pwm_audio dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .left_audio_pin(left_audio_pin), .right_audio_pin(right_audio_pin),
        .period_pulse(period_pulse), .cpu_clock_source_select(cpu_clock_source_select),
        .serial_clock_pin(serial_clock_pin), .serial_out_pin(serial_out_pin),
        .serial_in_pin(serial_in_pin), .flash_select_pin_n(flash_select_pin_n),
        .active_left_duty(active_left_duty)
    );

    spa_flash_model flash_u (
        .sclk(serial_clock_pin), .mosi(serial_out_pin), .cs_n(flash_select_pin_n),
        .miso(serial_in_pin), .last_cmd(last_cmd), .last_addr(last_addr)
    );

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles; the ceiling leaves ample margin
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 50000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One single AHB transfer; read data lands in rd at the data-phase edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic meas(input int n);
        nl = 0;
        nr = 0;
        np = 0;
        repeat (8) @(negedge hclk);
        repeat (n) begin
            @(negedge hclk);
            nl += int'(left_audio_pin === 1'b1);
            nr += int'(right_audio_pin === 1'b1);
            np += int'(period_pulse === 1'b1);
        end
    endtask

    task automatic wait_pulse();
        for (int i = 0; i < 100; i++) begin
            @(negedge hclk);
            if (period_pulse === 1'b1) break;
        end
    endtask

    // Polling a valid sample consumes it, so the last read holds the low nibble
    task automatic poll();
        for (int i = 0; i < 400; i++) begin
            bus(`SPA_ADDR_SAMPLE, 1'b0, 32'h0);
            if (rd[4] === 1'b1) break;
        end
    endtask

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        chk(cpu_clock_source_select, 32'h1);
        bus(`SPA_ADDR_CLKSEL, 1'b0, 32'h0);
        chk(rd, 32'h1);
        chk(hresp, 32'h0);
        bus(`SPA_ADDR_PERIOD, 1'b0, 32'h0);
        chk(rd, `SPA_PERIOD_RST);
        bus(8'h3c, 1'b0, 32'h0);
        chk(rd, 32'h0);
        bus(`SPA_ADDR_CLKSEL, 1'b1, 32'h0);
        // Register lands at the data-phase edge, the pin flop follows a cycle later
        repeat (2) @(negedge hclk);
        chk(cpu_clock_source_select, 32'h0);
        // Plain mode, period of 4 cycles, right duty beyond the period
        bus(`SPA_ADDR_PERIOD, 1'b1, 32'h3);
        bus(`SPA_ADDR_LEFT, 1'b1, 32'h2);
        bus(`SPA_ADDR_RIGHT, 1'b1, 32'h4);
        bus(`SPA_ADDR_MODE, 1'b1, 32'h1);
        meas(40);
        chk(nl, 20);
        chk(nr, 40);
        chk(np, 10);
        bus(`SPA_ADDR_STATUS, 1'b0, 32'h0);
        chk(rd[0], 32'h1);
        bus(`SPA_ADDR_LEFT, 1'b1, 32'h0);
        // Register, active compare and debug copy each add one flop
        repeat (3) @(negedge hclk);
        chk(active_left_duty, 32'h0);
        meas(40);
        chk(nl, 0);
        bus(`SPA_ADDR_MODE, 1'b1, 32'h0);
        bus(`SPA_ADDR_COUNT, 1'b0, 32'h0);
        chk(rd, 32'h0);
        chk({right_audio_pin, left_audio_pin}, 32'h0);
        // Counter stopped, so no new event can set the flag again
        bus(`SPA_ADDR_STATUS, 1'b1, 32'h1);
        bus(`SPA_ADDR_STATUS, 1'b0, 32'h0);
        chk(rd[0], 32'h0);
        // Buffered mode: staged duty only moves at the wrap
        bus(`SPA_ADDR_PERIOD, 1'b1, 32'h9);
        bus(`SPA_ADDR_PERIOD, 1'b0, 32'h0);
        chk(rd, 32'h9);
        bus(`SPA_ADDR_CHAN0, 1'b1, 32'h5);
        bus(`SPA_ADDR_MODE, 1'b1, 32'h3);
        wait_pulse();
        wait_pulse();
        bus(`SPA_ADDR_CHAN0, 1'b1, 32'h7);
        @(negedge hclk);
        chk(active_left_duty, 32'h5);
        wait_pulse();
        @(negedge hclk);
        chk(active_left_duty, 32'h7);
        meas(40);
        chk(nl, 28);
        chk(nr, 16);
        // Sample fetch over the serial link
        bus(`SPA_ADDR_MODE, 1'b1, 32'h0);
        bus(`SPA_ADDR_FADDR, 1'b1, 32'h123);
        bus(`SPA_ADDR_STREAM, 1'b1, 32'h1);
        poll();
        chk(rd[4:0], 32'h19);
        bus(`SPA_ADDR_STATUS, 1'b0, 32'h0);
        chk(rd[2:1], 32'h2);
        bus(`SPA_ADDR_SAMPLE, 1'b0, 32'h0);
        chk(rd[4:0], 32'h17);
        chk(last_cmd, `SPA_FLASH_READ_CMD);
        chk(last_addr, 32'h123);
        poll();
        chk(rd[4:0], 32'h1e);
        bus(`SPA_ADDR_SAMPLE, 1'b0, 32'h0);
        chk(rd[4:0], 32'h17);
        chk(last_addr, 32'h124);
        bus(`SPA_ADDR_STREAM, 1'b1, 32'h0);
        finish_test();
    end
endmodule
